/* scan_cfg_pkg.sv */
// Constants and types for the scan configuration decoder.
// Assumes a single 40 MHz clock domain and an AHB-Lite register port.
package scan_cfg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  CFG_ADDR    = 8'h00;
  localparam logic [7:0]  STAT_ADDR   = 8'h04;
  localparam logic [7:0]  SMP_ADDR    = 8'h08;
  localparam logic [15:0] CFG_RESET   = 16'h0000;

  // ****************************************************************
  // Field layout of the configuration and status words
  // ****************************************************************
  localparam int CODE_LSB  = 11;
  localparam int CODE_W    = 5;
  localparam int SEL_W     = 6;
  localparam int CFG_W     = 16;
  localparam int STAT_VLD  = 31;

  // ****************************************************************
  // Joint buffer / block codes
  // ****************************************************************
  localparam logic [4:0] C128_B8   = 5'h0D;
  localparam logic [4:0] C128_B16  = 5'h0E;
  localparam logic [4:0] C128_B32  = 5'h0F;
  localparam logic [4:0] C128_B64  = 5'h10;
  localparam logic [4:0] C256_B1   = 5'h11;
  localparam logic [4:0] C512_B1   = 5'h16;
  localparam logic [4:0] C1024_B1  = 5'h1B;

  localparam logic [10:0] DEPTH_128  = 11'h080;
  localparam logic [10:0] DEPTH_256  = 11'h100;
  localparam logic [10:0] DEPTH_512  = 11'h200;
  localparam logic [10:0] DEPTH_1024 = 11'h400;

  typedef enum logic [2:0] {
    BLK_1  = 3'b000,
    BLK_8  = 3'b001,
    BLK_16 = 3'b010,
    BLK_32 = 3'b011,
    BLK_64 = 3'b100,
    BLK_NONE = 3'b111
  } blk_t;

  typedef struct packed {
    logic        valid;
    blk_t        blk;
    logic [10:0] depth;
    logic [5:0]  firstCh;
    logic [6:0]  count;
  } scan_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } state_t;

endpackage : scan_cfg_pkg

/* scan_buffer_config_decode.sv */
// Scan configuration decoder with a scan sequencer and AHB-Lite registers.
// Assumes one 40 MHz clock, synchronous active-low reset, single-word bus.
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module scan_buffer_config_decode (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scanStart,
  output logic      [5:0]  sampleChannel,
  output logic      [9:0]  bufferAddr,
  output logic             sampleStrobe,
  output logic             scanBusy
);

  // ****************************************************************
  // Decode functions
  // ****************************************************************
  function automatic scan_cfg_pkg::scan_t decode(input logic [15:0] w);
    logic [4:0] c;
    logic [5:0] s;
    logic [4:0] off;
    scan_cfg_pkg::scan_t r;
    c = w[scan_cfg_pkg::CODE_LSB +: scan_cfg_pkg::CODE_W];
    s = w[scan_cfg_pkg::SEL_W-1:0];
    r = '0;
    r.blk = scan_cfg_pkg::BLK_NONE;
    off = 5'h00;
    if (c >= scan_cfg_pkg::C128_B8 && c <= scan_cfg_pkg::C128_B64) begin
      r.depth = scan_cfg_pkg::DEPTH_128;
      off = 5'(c - scan_cfg_pkg::C128_B8 + 5'h01);
    end else if (c >= scan_cfg_pkg::C1024_B1) begin
      r.depth = scan_cfg_pkg::DEPTH_1024;
      off = 5'(c - scan_cfg_pkg::C1024_B1);
    end else if (c >= scan_cfg_pkg::C512_B1) begin
      r.depth = scan_cfg_pkg::DEPTH_512;
      off = 5'(c - scan_cfg_pkg::C512_B1);
    end else if (c >= scan_cfg_pkg::C256_B1) begin
      r.depth = scan_cfg_pkg::DEPTH_256;
      off = 5'(c - scan_cfg_pkg::C256_B1);
    end
    if (r.depth != 11'h000) begin
      r.valid = 1'b1;
      unique case (off[2:0])
        3'b000: begin
          r.blk = scan_cfg_pkg::BLK_1;
          r.firstCh = s;
          r.count = 7'h01;
        end
        3'b001: begin
          r.blk = scan_cfg_pkg::BLK_8;
          r.firstCh = {s[2:0], 3'b000};
          r.count = 7'h08;
        end
        3'b010: begin
          r.blk = scan_cfg_pkg::BLK_16;
          r.firstCh = {s[2:1], 4'h0};
          r.count = 7'h10;
        end
        3'b011: begin
          r.blk = scan_cfg_pkg::BLK_32;
          r.firstCh = {s[2], 5'h00};
          r.count = 7'h20;
        end
        default: begin
          r.blk = scan_cfg_pkg::BLK_64;
          r.firstCh = 6'h00;
          r.count = 7'h40;
        end
      endcase
    end
    return r;
  endfunction : decode

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic        wrPend_r, wrPend_nxt;
  logic [7:0]  addr_r, addr_nxt;
  logic [15:0] cfg_r, cfg_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        accept;
  scan_cfg_pkg::scan_t dec;

  // Channel configuration register keeps code and selection fields
  assign dec = decode(cfg_r);
  assign accept = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  scan_cfg_pkg::state_t state_r, state_nxt;
  logic [10:0] wordCnt_r, wordCnt_nxt;
  logic [6:0]  chIdx_r, chIdx_nxt;
  logic        strobe_r, strobe_nxt;
  logic [5:0]  ch_r, ch_nxt;
  logic [9:0]  ba_r, ba_nxt;

  always_comb begin
    wrPend_nxt = accept && hwrite;
    addr_nxt = accept ? haddr : addr_r;
    cfg_nxt = cfg_r;
    rdata_nxt = rdata_r;
    // Writes load cfg_r in the data phase even while a scan runs; the scan keeps its held values
    if (wrPend_r && addr_r == scan_cfg_pkg::CFG_ADDR) begin
      cfg_nxt = hwdata[15:0];
    end
    if (accept && !hwrite) begin
      unique case (haddr)
        scan_cfg_pkg::CFG_ADDR: rdata_nxt = {16'h0000, cfg_nxt};
        scan_cfg_pkg::STAT_ADDR: rdata_nxt = {dec.valid, 7'h00,
          5'h00, dec.blk, 5'h00, dec.depth};
        scan_cfg_pkg::SMP_ADDR: rdata_nxt = {21'h000000,
          wordCnt_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      addr_r <= 8'h00;
      cfg_r <= scan_cfg_pkg::CFG_RESET;
      rdata_r <= 32'h00000000;
    end else begin
      wrPend_r <= wrPend_nxt;
      addr_r <= addr_nxt;
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Scan sequencer
  // ****************************************************************
  logic startSync1_r, startSync2_r, startOld_r;
  logic [10:0] depthHold_r, depthHold_nxt;
  logic [6:0]  cntHold_r, cntHold_nxt;
  logic [5:0]  baseHold_r, baseHold_nxt;

  always_comb begin
    state_nxt = state_r;
    wordCnt_nxt = wordCnt_r;
    chIdx_nxt = chIdx_r;
    strobe_nxt = 1'b0;
    ch_nxt = ch_r;
    ba_nxt = ba_r;
    depthHold_nxt = depthHold_r;
    cntHold_nxt = cntHold_r;
    baseHold_nxt = baseHold_r;
    unique case (state_r)
      scan_cfg_pkg::ST_IDLE: begin
        if (startSync2_r && !startOld_r && dec.valid) begin
          state_nxt = scan_cfg_pkg::ST_RUN;
          depthHold_nxt = dec.depth;
          cntHold_nxt = dec.count;
          baseHold_nxt = dec.firstCh;
          wordCnt_nxt = 11'h000;
          chIdx_nxt = 7'h00;
        end
      end
      scan_cfg_pkg::ST_RUN: begin
        // Ascending channels into consecutive words, wrap in group
        strobe_nxt = 1'b1;
        ch_nxt = 6'(baseHold_r + chIdx_r[5:0]);
        ba_nxt = wordCnt_r[9:0];
        wordCnt_nxt = 11'(wordCnt_r + 11'h001);
        chIdx_nxt = (7'(chIdx_r + 7'h01) == cntHold_r) ? 7'h00
          : 7'(chIdx_r + 7'h01);
        if (11'(wordCnt_r + 11'h001) == depthHold_r) begin
          state_nxt = scan_cfg_pkg::ST_DONE;
        end
      end
      scan_cfg_pkg::ST_DONE: state_nxt = scan_cfg_pkg::ST_IDLE;
      default: state_nxt = scan_cfg_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= scan_cfg_pkg::ST_IDLE;
      wordCnt_r <= 11'h000;
      chIdx_r <= 7'h00;
      strobe_r <= 1'b0;
      ch_r <= 6'h00;
      ba_r <= 10'h000;
      depthHold_r <= 11'h000;
      cntHold_r <= 7'h00;
      baseHold_r <= 6'h00;
      startSync1_r <= 1'b0;
      startSync2_r <= 1'b0;
      startOld_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wordCnt_r <= wordCnt_nxt;
      chIdx_r <= chIdx_nxt;
      strobe_r <= strobe_nxt;
      ch_r <= ch_nxt;
      ba_r <= ba_nxt;
      depthHold_r <= depthHold_nxt;
      cntHold_r <= cntHold_nxt;
      baseHold_r <= baseHold_nxt;
      startSync1_r <= scanStart;
      startSync2_r <= startSync1_r;
      startOld_r <= startSync2_r;
    end
  end

  assign sampleChannel = ch_r;
  assign bufferAddr = ba_r;
  assign sampleStrobe = strobe_r;
  assign scanBusy = (state_r != scan_cfg_pkg::ST_IDLE);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  code_128_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_r[15:11] == 5'h10 |-> dec.blk == scan_cfg_pkg::BLK_64
    && dec.depth == 11'h080)
    else $error("128 word code wrong");
  code_256_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_r[15:11] == 5'h12 |-> dec.blk == scan_cfg_pkg::BLK_8
    && dec.depth == 11'h100)
    else $error("256 word code wrong");
  code_512_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_r[15:11] == 5'h19 |-> dec.blk == scan_cfg_pkg::BLK_32
    && dec.depth == 11'h200)
    else $error("512 word code wrong");
  code_1024_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_r[15:11] == 5'h1C |-> dec.blk == scan_cfg_pkg::BLK_8
    && dec.depth == 11'h400)
    else $error("1024 word code wrong");
  single_ch_a: assert property (@(posedge clock) disable iff (!rst_n)
    dec.blk == scan_cfg_pkg::BLK_1 |-> dec.firstCh == cfg_r[5:0])
    else $error("single channel wrong");
  grp8_a: assert property (@(posedge clock) disable iff (!rst_n)
    dec.blk == scan_cfg_pkg::BLK_8 |-> dec.firstCh[5:3] == cfg_r[2:0])
    else $error("group of 8 wrong");
  grp16_a: assert property (@(posedge clock) disable iff (!rst_n)
    dec.blk == scan_cfg_pkg::BLK_16 |-> dec.firstCh == {cfg_r[2:1],
    4'h0})
    else $error("group of 16 wrong");
  grp32_a: assert property (@(posedge clock) disable iff (!rst_n)
    dec.blk == scan_cfg_pkg::BLK_32 |-> dec.firstCh[5] == cfg_r[2]
    && dec.count == 7'h20)
    else $error("group of 32 wrong");
  all64_a: assert property (@(posedge clock) disable iff (!rst_n)
    dec.blk == scan_cfg_pkg::BLK_64 |-> dec.firstCh == 6'h00)
    else $error("all channels wrong");
  word_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    strobe_r && $past(strobe_r) |-> bufferAddr == 10'($past(ba_r) + 1))
    else $error("buffer words not consecutive");
  code_b16_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_r[15:11] == 5'h0E |-> dec.blk == scan_cfg_pkg::BLK_16
    && dec.depth == 11'h080)
    else $error("128 word block 16 code wrong");
  code_b1_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_r[15:11] == 5'h1B |-> dec.blk == scan_cfg_pkg::BLK_1
    && dec.depth == 11'h400)
    else $error("1024 word block 1 code wrong");
  // Wrap inside the group keeps every sample in the chosen block
  ch_range_a: assert property (@(posedge clock) disable iff (!rst_n)
    strobe_r |-> 7'(6'(ch_r - baseHold_r)) < cntHold_r)
    else $error("channel outside group");
  scan_end_a: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == scan_cfg_pkg::ST_DONE |-> wordCnt_r == depthHold_r)
    else $error("scan ended at wrong word count");
  run_cover: cover property (@(posedge clock) disable iff (!rst_n)
    state_r == scan_cfg_pkg::ST_DONE);
  blk1_cover: cover property (@(posedge clock) disable iff (!rst_n)
    scanBusy && cntHold_r == 7'h01);
  blk64_cover: cover property (@(posedge clock) disable iff (!rst_n)
    scanBusy && cntHold_r == 7'h40);
  blk8_cover: cover property (@(posedge clock) disable iff (!rst_n)
    scanBusy && cntHold_r == 7'h08);

endmodule : scan_buffer_config_decode
`default_nettype wire

/* scan_buffer_config_decode_tb_top.sv */
// Self-checking bench for the scan configuration decoder.
// Assumes the bench is the only bus master and drives scanStart itself.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin nTests++; \
  if ((got) !== (exp)) begin badCount++; \
  $display("Error t=%0t got=%0h exp=%0h", $time, got, exp); end end
module scan_buffer_config_decode_tb_top;
  // ****************************************************************
  // Signals and stimulus tables
  // ****************************************************************
  logic        clock;
  logic        rst_n;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  logic  hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        scanStart;
  logic [5:0]  sampleChannel;
  logic [9:0]  bufferAddr;
  logic        sampleStrobe;
  logic        scanBusy;
  int          badCount;
  int          nTests;
  logic [31:0] rd;
  // Code, expected block encoding, expected depth
  logic [18:0] rows [19] = '{
    {5'h0D, 3'h1, 11'h080}, {5'h0E, 3'h2, 11'h080}, {5'h0F, 3'h3, 11'h080},
    {5'h10, 3'h4, 11'h080}, {5'h11, 3'h0, 11'h100}, {5'h12, 3'h1, 11'h100},
    {5'h13, 3'h2, 11'h100}, {5'h14, 3'h3, 11'h100}, {5'h15, 3'h4, 11'h100},
    {5'h16, 3'h0, 11'h200}, {5'h17, 3'h1, 11'h200}, {5'h18, 3'h2, 11'h200},
    {5'h19, 3'h3, 11'h200}, {5'h1A, 3'h4, 11'h200}, {5'h1B, 3'h0, 11'h400},
    {5'h1C, 3'h1, 11'h400}, {5'h1D, 3'h2, 11'h400}, {5'h1E, 3'h3, 11'h400},
    {5'h1F, 3'h4, 11'h400}};
  // Code, selection, first channel, group size, depth
  int          scans [5][5] = '{'{'h0D, 'h3D, 40, 8, 128},
    '{'h0E, 'h3B, 16, 16, 128}, '{'h0F, 'h3C, 32, 32, 128},
    '{'h10, 'h2A, 0, 64, 128}, '{'h11, 'h2A, 42, 1, 256}};

  assign hready = hreadyout;

  scan_buffer_config_decode dut (
    .clock         (clock),
    .rst_n         (rst_n),
    .hsel          (hsel),
    .haddr         (haddr),
    .htrans        (htrans),
    .hwrite        (hwrite),
    .hsize         (hsize),
    .hwdata        (hwdata),
    .hready        (hready),
    .hrdata        (hrdata),
    .hreadyout     (hreadyout),
    .hresp         (hresp),
    .scanStart     (scanStart),
    .sampleChannel (sampleChannel),
    .bufferAddr    (bufferAddr),
    .sampleStrobe  (sampleStrobe),
    .scanBusy      (scanBusy)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ****************************************************************
  // Bus and scan tasks
  // ****************************************************************
  task automatic waitReady();
    do begin
      @(posedge clock);
    end while (hreadyout !== 1'b1);
    `CHK(hresp, 1'b0)
  endtask : waitReady

  task automatic busXfer(input logic [7:0] a, input logic w,
                         input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    waitReady();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    waitReady();
    q = hrdata;
  endtask : busXfer

  // Strobes are looked at 1 ns after each edge, so each is seen once
  task automatic runScan(input int code, input int sel, input int base,
                         input int size, input int depth);
    int i;
    int k;
    i = 0;
    busXfer(scan_cfg_pkg::CFG_ADDR, 1'b1,
            {16'h0000, 5'(code), 5'h15, 6'(sel)}, rd);
    @(posedge clock);
    scanStart <= 1'b1;
    for (k = 0; k < 1200; k++) begin
      @(posedge clock);
      if (k == 4) scanStart <= 1'b0;
      #1;
      if (sampleStrobe === 1'b1) begin
        `CHK(sampleChannel, 6'(base + (i % size)))
        `CHK(bufferAddr, 10'(i))
        i++;
      end
      if (k > 6 && scanBusy !== 1'b1) break;
    end
    `CHK(i, depth)
  endtask : runScan

  task automatic tallyAndFinish();
    if (badCount == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tallyAndFinish

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    hsel      = 1'b0;
    haddr     = 8'h00;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    hsize     = 3'b010;
    hwdata    = 32'h00000000;
    scanStart = 1'b0;
    rst_n     = 1'b0;
    badCount  = 0;
    nTests    = 0;
    repeat (4) @(posedge clock);
    `CHK(scanBusy, 1'b0)
    `CHK(sampleStrobe, 1'b0)
    rst_n <= 1'b1;
    busXfer(scan_cfg_pkg::CFG_ADDR, 1'b0, 32'h00000000, rd);
    `CHK(rd, {16'h0000, scan_cfg_pkg::CFG_RESET})
    for (int r = 0; r < 19; r++) begin
      busXfer(scan_cfg_pkg::CFG_ADDR, 1'b1,
              {16'hA5A5, rows[r][18:14], 5'h0A, 6'h15}, rd);
      busXfer(scan_cfg_pkg::CFG_ADDR, 1'b0, 32'h00000000, rd);
      `CHK(rd, {16'h0000, rows[r][18:14], 5'h0A, 6'h15})
      busXfer(scan_cfg_pkg::STAT_ADDR, 1'b0, 32'h00000000, rd);
      `CHK({rd[31], rd[18:16], rd[10:0]}, {1'b1, rows[r][13:0]})
    end
    for (int s = 0; s < 5; s++) begin
      runScan(scans[s][0], scans[s][1], scans[s][2], scans[s][3],
              scans[s][4]);
    end
    busXfer(scan_cfg_pkg::SMP_ADDR, 1'b0, 32'h00000000, rd);
    `CHK(rd, 32'h00000100)
    // A code below the decoded range must not start anything
    runScan('h0C, 'h00, 0, 1, 0);
    busXfer(scan_cfg_pkg::STAT_ADDR, 1'b0, 32'h00000000, rd);
    `CHK(rd[31], 1'b0)
    busXfer(8'h0C, 1'b0, 32'h00000000, rd);
    `CHK(rd, 32'h00000000)
    busXfer(8'h10, 1'b1, 32'hFFFFFFFF, rd);
    busXfer(scan_cfg_pkg::CFG_ADDR, 1'b0, 32'h00000000, rd);
    `CHK(rd[15:11], 5'h0C)
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    busXfer(scan_cfg_pkg::CFG_ADDR, 1'b0, 32'h00000000, rd);
    `CHK(rd, {16'h0000, scan_cfg_pkg::CFG_RESET})
    tallyAndFinish();
  end

  // Whole run needs about 1000 cycles; twenty times that is a hang
  initial begin
    repeat (20000) @(posedge clock);
    badCount++;
    tallyAndFinish();
  end
endmodule : scan_buffer_config_decode_tb_top
`default_nettype wire
